// File: core/cdl_pkg.sv
// Shared constants and types for the two-codec digital sample path.
package cdl_pkg;

	localparam int CDL_NUM_CODECS = 2;
	localparam int CDL_WORD_W = 16;
	localparam int CDL_BUS_W = 32;
	localparam int CDL_ADDR_W = 8;
	localparam int CDL_CTRL_W = 9;
	localparam int CDL_HTRANS_ACTIVE_BIT = 1;

	// Register map, byte addresses; codec n sits at n * stride.
	localparam logic [7:0] CDL_CODEC_STRIDE = 8'h10;
	localparam logic [7:0] CDL_OFF_CTRL = 8'h00;
	localparam logic [7:0] CDL_OFF_RESULT = 8'h04;
	localparam logic [7:0] CDL_OFF_DAC = 8'h08;
	localparam logic [7:0] CDL_OFF_STATUS = 8'h0c;
	localparam logic [7:0] CDL_OFF_CHAN = 8'h20;

	localparam int CDL_STAT_READY_BIT = 0;
	localparam int CDL_STAT_OVR_BIT = 1;

	// Sample rate codes.
	localparam logic [1:0] CDL_RATE_48K = 2'h0;
	localparam logic [1:0] CDL_RATE_44K1 = 2'h1;
	localparam logic [1:0] CDL_RATE_8K = 2'h2;
	localparam logic [1:0] CDL_RATE_16K = 2'h3;

	// Microphone gain steps 0..5 are 0 dB to 30.10 dB in 6.02 dB steps.
	localparam logic [2:0] CDL_GAIN_MAX = 3'h5;

	// Channel mix codes for the processing path.
	localparam logic [1:0] CDL_CHAN_4X8 = 2'h0;
	localparam logic [1:0] CDL_CHAN_2X16 = 2'h1;
	localparam logic [1:0] CDL_CHAN_2X8_1X16 = 2'h2;
	localparam logic [1:0] CDL_CHAN_BAD = 2'h3;

	// Control word, laid out as in the control register from bit 8 down.
	typedef struct packed {
		logic par_lb;
		logic dig_lb;
		logic pd;
		logic [2:0] gain;
		logic line_mode;
		logic [1:0] rate;
	} cdl_ctrl_s;

	localparam cdl_ctrl_s CDL_CTRL_RST = '0;

	typedef struct packed {
		logic valid;
		logic [CDL_WORD_W-1:0] word;
	} cdl_word_s;

	typedef enum logic {
		CDL_SER_IDLE,
		CDL_SER_SHIFT
	} cdl_ser_e;

endpackage

// File: core/cdl_codec_path.sv
// One codec's digital path: result word, DAC serializer, loopbacks.
`timescale 1ns/1ps
module cdl_codec_path
	import cdl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input cdl_ctrl_s ctrl,
	input cdl_word_s dac_in,
	input cdl_word_s adc_in,
	input wire logic adc_pdm_bit,
	input wire logic dac_mod_pdm_bit,
	input wire logic ser_load,
	output logic [CDL_WORD_W-1:0] result_q,
	output logic result_evt,
	output logic ser_bit,
	output logic ser_valid,
	output logic recon_pdm_q
);

	localparam int CNT_W = $clog2(CDL_WORD_W);
	localparam logic [CDL_WORD_W-1:0] MOST_NEG = {1'b1, {(CDL_WORD_W-1){1'b0}}};
	localparam logic [CDL_WORD_W-1:0] NEG_FS = MOST_NEG + 1'b1;
	localparam logic [CNT_W-1:0] SER_LAST = CNT_W'(CDL_WORD_W - 1);
	localparam logic [CNT_W:0] RUN_FULL = (CNT_W+1)'(CDL_WORD_W);

	logic [CDL_WORD_W-1:0] dac_q;
	logic [CDL_WORD_W-1:0] par_q;
	logic [CDL_WORD_W-1:0] shift_q;
	logic [CNT_W-1:0] cnt_q;
	cdl_ser_e state_q;
	cdl_ser_e state_d;
	logic [CNT_W:0] run_q;

	// [R13] parallel loop wins
	wire par_on = ctrl.par_lb & ~ctrl.pd;
	wire dig_on = ctrl.dig_lb & ~ctrl.par_lb & ~ctrl.pd;
	// [R9] symmetric full scale
	wire [CDL_WORD_W-1:0] adc_sat = (adc_in.word == MOST_NEG) ? NEG_FS : adc_in.word;
	// [R5] written word returned
	wire res_load = ~ctrl.pd & (dig_on ? dac_in.valid : adc_in.valid);
	wire [CDL_WORD_W-1:0] res_src = dig_on ? dac_in.word : adc_sat;
	// [R7] writes dropped in loop
	wire dac_take = dac_in.valid & ~par_on & ~ctrl.pd;
	// [R6] decimated word to interpolator
	wire [CDL_WORD_W-1:0] ser_src = par_on ? par_q : dac_q;
	wire ser_start = ser_load & ~ctrl.pd & (state_q == CDL_SER_IDLE);
	wire ser_end = (state_q == CDL_SER_SHIFT) && (cnt_q == SER_LAST);
	// [R4] modulator bits to filter
	wire recon_d = dig_on ? adc_pdm_bit : dac_mod_pdm_bit;

	assign result_evt = res_load & ce;
	assign ser_bit = shift_q[CDL_WORD_W-1];
	assign ser_valid = (state_q == CDL_SER_SHIFT);

	always_comb begin
		state_d = state_q;
		case (state_q)
			CDL_SER_IDLE: if (ser_start) state_d = CDL_SER_SHIFT;
			CDL_SER_SHIFT: if (ser_end) state_d = CDL_SER_IDLE;
			default: state_d = CDL_SER_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			result_q <= '0;
			dac_q <= '0;
			par_q <= '0;
			recon_pdm_q <= 1'b0;
		end else if (ce) begin
			if (res_load) result_q <= res_src;
			if (dac_take) dac_q <= dac_in.word;
			if (adc_in.valid && !ctrl.pd) par_q <= adc_sat;
			recon_pdm_q <= recon_d;
		end
	end

	// [R2] serialize DAC word
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= CDL_SER_IDLE;
			shift_q <= '0;
			cnt_q <= '0;
		end else if (ce) begin
			state_q <= state_d;
			if (ser_start) begin
				shift_q <= ser_src;
				cnt_q <= '0;
			end else if (ser_valid) begin
				shift_q <= {shift_q[CDL_WORD_W-2:0], 1'b0};
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// Independent count of shift cycles, so the length check does not
	// lean on the serializer's own counter.
	always_ff @(posedge core_clk) begin
		if (rst) run_q <= '0;
		else if (ce) run_q <= ser_valid ? run_q + 1'b1 : '0;
	end

	a_recon_pdm_src: assert property (@(posedge core_clk) disable iff (rst) // R4
		ce |=> recon_pdm_q ==
		($past(ctrl.dig_lb & ~ctrl.par_lb & ~ctrl.pd) ?
		$past(adc_pdm_bit) : $past(dac_mod_pdm_bit)))
		else $error("reconstruction bit from wrong source");
	a_dig_loop_word: assert property (@(posedge core_clk) disable iff (rst) // R5
		(ce && dig_on && dac_in.valid) |=> result_q == $past(dac_in.word))
		else $error("loopback word not returned");
	a_par_loop_feed: assert property (@(posedge core_clk) disable iff (rst) // R6
		(ce && ser_start && par_on) |=> shift_q == $past(par_q))
		else $error("parallel loop word not fed");
	a_par_dac_drop: assert property (@(posedge core_clk) disable iff (rst) // R7
		(ce && par_on && dac_in.valid) |=> $stable(dac_q))
		else $error("DAC write kept in parallel loop");
	a_adc_sat_range: assert property (@(posedge core_clk) disable iff (rst) // R9
		(ce && res_load && !dig_on) |=> result_q != MOST_NEG)
		else $error("result word below negative full scale");
	a_loop_priority: assert property (@(posedge core_clk) disable iff (rst) // R13
		(ce && ctrl.par_lb && ctrl.dig_lb && !ctrl.pd && adc_in.valid)
		|=> result_q == $past(adc_sat))
		else $error("digital loop overrode parallel loop");
	a_ser_word_start: assert property (@(posedge core_clk) // R2
		disable iff (rst) (ce && ser_start) |=> ser_valid && cnt_q == '0)
		else $error("serializer did not start");
	a_ser_word_len: assert property (@(posedge core_clk) // R2
		disable iff (rst) $fell(ser_valid) |-> run_q == RUN_FULL)
		else $error("serializer length wrong");

endmodule

// File: core/cdl_codec_top.sv
// Register front end over AHB-Lite and the two codec digital paths.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] ADC result readable as 16-bit word.
// [R2] DAC words serialized toward interpolation.
// [R3] Rate selectable: 48, 44.1, 8, 16 kHz.
// [R4] Digital loop: ADC bits to reconstruction.
// [R5] Digital loop returns written DAC word.
// [R6] Parallel loop: decimator word to interpolator.
// [R7] Parallel loop: result readable, writes dropped.
// [R8] Each codec powers down on its own.
// [R9] Results two's complement, plus/minus 32767. The digital loop returns a written 16'h8000 unchanged.
// [R10] Input buffer: microphone or line mode.
// [R11] Microphone gain has six steps.
// [R12] Channel mix limited to three layouts.
// [R13] Parallel loop beats digital loop.
module cdl_codec_top
	import cdl_pkg::*;
#(
	parameter int NUM_CODECS = CDL_NUM_CODECS
)(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [CDL_BUS_W-1:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [CDL_BUS_W-1:0] hrdata,
	output logic hresp,
	input cdl_word_s adc_dec_in [NUM_CODECS],
	input wire logic [NUM_CODECS-1:0] adc_pdm_bit,
	input wire logic [NUM_CODECS-1:0] dac_mod_pdm_bit,
	input wire logic [NUM_CODECS-1:0] ser_load,
	output logic [NUM_CODECS-1:0] ser_bit,
	output logic [NUM_CODECS-1:0] ser_valid,
	output logic [NUM_CODECS-1:0] recon_pdm_bit,
	output cdl_ctrl_s codec_ctrl [NUM_CODECS],
	output logic [1:0] chan_cfg
);

	// ****************************************
	// Bus slave
	// ****************************************

	function automatic logic reg_hit(input logic [CDL_ADDR_W-1:0] a,
		input int c, input logic [7:0] off);
		return a == CDL_ADDR_W'(c * CDL_CODEC_STRIDE + off);
	endfunction

	logic wr_pend_q;
	logic [CDL_ADDR_W-1:0] wr_addr_q;
	logic [CDL_BUS_W-1:0] hrdata_q;
	logic [1:0] chan_q;
	logic [CDL_BUS_W-1:0] rd_any;
	logic [CDL_BUS_W-1:0] codec_rd [NUM_CODECS];
	cdl_ctrl_s ctrl_q [NUM_CODECS];
	logic [NUM_CODECS-1:0] ready_q;
	logic [NUM_CODECS-1:0] ovr_q;
	logic [NUM_CODECS-1:0] evt;

	wire [CDL_ADDR_W-1:0] a_addr = haddr[CDL_ADDR_W-1:0];
	wire addr_req = hsel & htrans[CDL_HTRANS_ACTIVE_BIT];
	// A read right behind a write waits one cycle so it sees the new value.
	wire rd_hazard = wr_pend_q & addr_req & ~hwrite;
	wire addr_take = addr_req & hready & ce;
	wire rd_take = addr_take & ~hwrite;
	wire wr_do = wr_pend_q & ce;
	wire chan_wr = wr_do & (wr_addr_q == CDL_OFF_CHAN);
	wire [1:0] chan_new = hwdata[1:0];
	wire chan_rd = a_addr == CDL_OFF_CHAN;
	wire cdl_ctrl_s wr_raw = cdl_ctrl_s'(hwdata[CDL_CTRL_W-1:0]);
	wire gain_over = wr_raw.gain > CDL_GAIN_MAX;
	wire [2:0] wr_gain = gain_over ? CDL_GAIN_MAX : wr_raw.gain;

	assign hreadyout = ce & ~rd_hazard;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	assign chan_cfg = chan_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
		end else if (ce) begin
			wr_pend_q <= addr_take & hwrite;
			if (addr_take) wr_addr_q <= a_addr;
		end
	end

	always_comb begin
		rd_any = chan_rd ? {{(CDL_BUS_W-2){1'b0}}, chan_q} : '0;
		for (int i = 0; i < NUM_CODECS; i++) begin
			rd_any = rd_any | codec_rd[i];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) hrdata_q <= '0;
		else if (rd_take) hrdata_q <= rd_any;
	end

	// [R12] illegal mix ignored
	always_ff @(posedge core_clk) begin
		if (rst) chan_q <= CDL_CHAN_4X8;
		else if (chan_wr && chan_new != CDL_CHAN_BAD) chan_q <= chan_new;
	end

	// ****************************************
	// Per-codec registers and paths
	// ****************************************

	generate
		for (genvar i = 0; i < NUM_CODECS; i++) begin : g_codec
			cdl_ctrl_s ctrl_new;
			cdl_word_s dac_wr;
			wire ctrl_wr = wr_do & reg_hit(wr_addr_q, i, CDL_OFF_CTRL);
			wire dac_hit = wr_do & reg_hit(wr_addr_q, i, CDL_OFF_DAC);
			wire stat_wr = wr_do & reg_hit(wr_addr_q, i, CDL_OFF_STATUS);
			wire res_rd = rd_take & reg_hit(a_addr, i, CDL_OFF_RESULT);
			wire ovr_clr = stat_wr & hwdata[CDL_STAT_OVR_BIT];
			wire [CDL_WORD_W-1:0] res_word;
			// [R1] fresh word flags
			wire ready_d = evt[i] | (ready_q[i] & ~res_rd);
			wire ovr_d = (evt[i] & ready_q[i] & ~res_rd) |
				(ovr_q[i] & ~ovr_clr);

			// [R11] gain clamped to six steps
			assign ctrl_new = '{par_lb: wr_raw.par_lb,
				dig_lb: wr_raw.dig_lb, pd: wr_raw.pd, gain: wr_gain,
				line_mode: wr_raw.line_mode, rate: wr_raw.rate};
			assign dac_wr = '{valid: dac_hit, word: hwdata[CDL_WORD_W-1:0]};
			assign codec_ctrl[i] = ctrl_q[i];
			assign codec_rd[i] =
				(reg_hit(a_addr, i, CDL_OFF_CTRL) ?
					{{(CDL_BUS_W-CDL_CTRL_W){1'b0}}, ctrl_q[i]} : '0) |
				(reg_hit(a_addr, i, CDL_OFF_RESULT) ?
					{{(CDL_BUS_W-CDL_WORD_W){1'b0}}, res_word} : '0) |
				(reg_hit(a_addr, i, CDL_OFF_STATUS) ?
					{{(CDL_BUS_W-2){1'b0}}, ovr_q[i], ready_q[i]} : '0);

			// [R10] buffer mode stored
			// [R3] rate, mode, power-down
			always_ff @(posedge core_clk) begin
				if (rst) ctrl_q[i] <= CDL_CTRL_RST;
				else if (ctrl_wr) ctrl_q[i] <= ctrl_new;
			end

			// [R1] set wins over clear
			always_ff @(posedge core_clk) begin
				if (rst) begin
					ready_q[i] <= 1'b0;
					ovr_q[i] <= 1'b0;
				end else if (ce) begin
					ready_q[i] <= ready_d;
					ovr_q[i] <= ovr_d;
				end
			end

			// [R8] power-down per codec
			cdl_codec_path u_path (
				.core_clk(core_clk),
				.rst(rst),
				.ce(ce),
				.ctrl(ctrl_q[i]),
				.dac_in(dac_wr),
				.adc_in(adc_dec_in[i]),
				.adc_pdm_bit(adc_pdm_bit[i]),
				.dac_mod_pdm_bit(dac_mod_pdm_bit[i]),
				.ser_load(ser_load[i]),
				.result_q(res_word),
				.result_evt(evt[i]),
				.ser_bit(ser_bit[i]),
				.ser_valid(ser_valid[i]),
				.recon_pdm_q(recon_pdm_bit[i])
			);

			a_result_flag_set: assert property (@(posedge core_clk) // R1
				disable iff (rst) evt[i] |=> ready_q[i])
				else $error("result flag not set by new word");
			a_ctrl_write_take: assert property (@(posedge core_clk) // R3
				disable iff (rst) ctrl_wr |=> ctrl_q[i].rate ==
				$past(wr_raw.rate) && codec_ctrl[i].pd == $past(wr_raw.pd)
				&& ctrl_q[i].line_mode == $past(wr_raw.line_mode))
				else $error("control write not applied");
			a_gain_step_max: assert property (@(posedge core_clk) // R11
				disable iff (rst) ctrl_q[i].gain <= CDL_GAIN_MAX)
				else $error("gain step out of range");
			a_pd_freezes_res: assert property (@(posedge core_clk) // R8
				disable iff (rst) ctrl_q[i].pd && !ctrl_wr |=> !evt[i])
				else $error("powered-down codec produced a word");
			c_dig_loop: cover property (@(posedge core_clk)
				ctrl_q[i].dig_lb && dac_hit && !ctrl_q[i].par_lb);
			c_par_loop: cover property (@(posedge core_clk)
				ctrl_q[i].par_lb && adc_dec_in[i].valid && ser_load[i]);
			c_overrun: cover property (@(posedge core_clk) ovr_q[i]);
		end
	endgenerate

	a_chan_mix_legal: assert property (@(posedge core_clk) // R12
		disable iff (rst) chan_q != CDL_CHAN_BAD)
		else $error("illegal channel mix stored");

endmodule

// File: verification/cdl_far_model.sv
// Behavioural decimators, modulators and interpolators beside both codecs.
`timescale 1ns/1ps
module cdl_far_model
	import cdl_pkg::*;
(
	input wire logic core_clk,
	input wire logic [1:0] ser_bit,
	input wire logic [1:0] ser_valid,
	output cdl_word_s adc_dec [CDL_NUM_CODECS],
	output logic [1:0] adc_pdm,
	output logic [1:0] dac_pdm,
	output logic [1:0] ser_load
);
	logic [3:0] cnt = 4'h0;
	initial begin
		adc_dec[0] = '0;
		adc_dec[1] = '0;
		ser_load = 2'h0;
	end
	// Patterns differ per source so a wrong mux choice shows up.
	always @(posedge core_clk) begin
		cnt <= cnt + 4'h1;
	end
	assign adc_pdm = {cnt[1], cnt[0]};
	assign dac_pdm = {cnt[3] ^ cnt[0], cnt[2]};
	// An idle word bus shows the inverse, never a stale copy.
	task automatic send(input int c, input logic [15:0] w);
		@(posedge core_clk);
		adc_dec[c] <= '{1'b1, w};
		@(posedge core_clk);
		adc_dec[c] <= '{1'b0, ~w};
	endtask
	task automatic pull(input int c, output logic [15:0] w, output int n);
		n = 0;
		w = '0;
		@(posedge core_clk);
		ser_load[c] <= 1'b1;
		@(posedge core_clk);
		ser_load[c] <= 1'b0;
		repeat (16) begin
			#1;
			w = {w[14:0], ser_bit[c]};
			n += int'(ser_valid[c] === 1'b1);
			@(posedge core_clk);
		end
	endtask
endmodule

// File: verification/tb_top.sv
// Self-checking bench for the two-codec register front end.
`timescale 1ns/1ps
module tb_top;
	import cdl_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic hreadyout, hresp;
	logic [31:0] hrdata, rd;
	cdl_word_s adc_dec [CDL_NUM_CODECS];
	logic [1:0] adc_pdm, dac_pdm, ser_load, ser_bit, ser_valid, recon;
	cdl_ctrl_s codec_ctrl [CDL_NUM_CODECS];
	logic [1:0] chan_cfg;
	logic [15:0] w;
	int n;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	cdl_codec_top dut (
		.core_clk(core_clk), .rst(rst), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .adc_dec_in(adc_dec),
		.adc_pdm_bit(adc_pdm), .dac_mod_pdm_bit(dac_pdm),
		.ser_load(ser_load), .ser_bit(ser_bit), .ser_valid(ser_valid),
		.recon_pdm_bit(recon), .codec_ctrl(codec_ctrl), .chan_cfg(chan_cfg)
	);
	cdl_far_model far (
		.core_clk(core_clk), .ser_bit(ser_bit), .ser_valid(ser_valid),
		.adc_dec(adc_dec), .adc_pdm(adc_pdm), .dac_pdm(dac_pdm),
		.ser_load(ser_load)
	);
	always #20 core_clk = ~core_clk;
	// ********************************
	// Shared bus and compare tasks
	// ********************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	function automatic logic [7:0] ra(input int c, input logic [7:0] off);
		return off + ((c == 1) ? CDL_CODEC_STRIDE : 8'h00);
	endfunction
	task automatic rec(input int c, input logic from_adc);
		logic e;
		repeat (6) begin
			@(posedge core_clk);
			e = from_adc ? adc_pdm[c] : dac_pdm[c];
			#1;
			chk({31'h0, recon[c]}, {31'h0, e});
		end
	endtask
	// ********************************
	// Scenarios
	// ********************************
	task automatic t_reset();
		rchk(ra(0, CDL_OFF_CTRL), 32'h0);
		rchk(CDL_OFF_CHAN, 32'h0);
		rchk(8'h40, 32'h0);
		chk({23'h0, codec_ctrl[1]}, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_ctrl();
		cdl_ctrl_s c;
		for (int r = 0; r < 4; r++) begin
			c = '0;
			c.rate = r[1:0];
			c.line_mode = r[0];
			c.gain = 3'h7 - r[2:0];
			bus(1'b1, ra(1, CDL_OFF_CTRL), {23'h0, c});
			if (c.gain > CDL_GAIN_MAX)
				c.gain = CDL_GAIN_MAX;
			rchk(ra(1, CDL_OFF_CTRL), {23'h0, c});
			chk({23'h0, codec_ctrl[1]}, {23'h0, c});
		end
		bus(1'b1, ra(1, CDL_OFF_CTRL), 32'h0);
		$display("test ctrl done");
	endtask
	task automatic t_adc();
		far.send(0, 16'h8000);
		rchk(ra(0, CDL_OFF_RESULT), 32'h8001);
		rchk(ra(0, CDL_OFF_STATUS), 32'h0);
		far.send(0, 16'h0001);
		far.send(0, 16'h7fff);
		rchk(ra(0, CDL_OFF_STATUS), 32'h3);
		bus(1'b1, ra(0, CDL_OFF_STATUS), 32'h2);
		rchk(ra(0, CDL_OFF_STATUS), 32'h1);
		rchk(ra(0, CDL_OFF_RESULT), 32'h7fff);
		$display("test adc done");
	endtask
	task automatic t_dac();
		bus(1'b1, ra(0, CDL_OFF_DAC), 32'ha5c3);
		rchk(ra(0, CDL_OFF_DAC), 32'h0);
		far.pull(0, w, n);
		chk({16'h0, w}, 32'ha5c3);
		chk(n, 32'd16);
		#1;
		chk({31'h0, ser_valid[0]}, 32'h0);
		$display("test dac done");
	endtask
	task automatic t_dig();
		bus(1'b1, ra(1, CDL_OFF_CTRL), 32'h80);
		bus(1'b1, ra(1, CDL_OFF_DAC), 32'hbeef);
		far.send(1, 16'h5555);
		rchk(ra(1, CDL_OFF_RESULT), 32'hbeef);
		rec(1, 1'b1);
		bus(1'b1, ra(1, CDL_OFF_CTRL), 32'h0);
		rec(1, 1'b0);
		$display("test digital loop done");
	endtask
	task automatic t_par();
		bus(1'b1, ra(0, CDL_OFF_CTRL), 32'h180);
		bus(1'b1, ra(0, CDL_OFF_DAC), 32'h0f0f);
		far.send(0, 16'h0777);
		far.pull(0, w, n);
		chk({16'h0, w}, 32'h0777);
		rchk(ra(0, CDL_OFF_RESULT), 32'h0777);
		bus(1'b1, ra(0, CDL_OFF_CTRL), 32'h0);
		far.pull(0, w, n);
		chk({16'h0, w}, 32'ha5c3);
		$display("test parallel loop done");
	endtask
	task automatic t_pd();
		bus(1'b1, ra(1, CDL_OFF_CTRL), 32'h40);
		#1;
		chk({31'h0, codec_ctrl[1].pd}, 32'h1);
		far.send(1, 16'h1111);
		rchk(ra(1, CDL_OFF_RESULT), 32'hbeef);
		far.pull(1, w, n);
		chk(n, 32'd0);
		far.send(0, 16'h3333);
		rchk(ra(0, CDL_OFF_RESULT), 32'h3333);
		$display("test power down done");
	endtask
	task automatic t_ce();
		@(posedge core_clk);
		ce <= 1'b0;
		far.send(0, 16'h1234);
		chk({31'h0, hreadyout}, 32'h0);
		ce <= 1'b1;
		rchk(ra(0, CDL_OFF_RESULT), 32'h3333);
		$display("test clock enable done");
	endtask
	task automatic t_chan();
		for (int k = 1; k < 4; k++) begin
			bus(1'b1, CDL_OFF_CHAN, 32'(k));
			rchk(CDL_OFF_CHAN, (k == 3) ? 32'h2 : 32'(k));
		end
		chk({30'h0, chan_cfg}, 32'h2);
		$display("test channel mix done");
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// The whole run needs well under a thousand cycles.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_ctrl();
		t_adc();
		t_dac();
		t_dig();
		t_par();
		t_pd();
		t_ce();
		t_chan();
		conclude();
	end
endmodule
